//--- src/scco_pkg.sv
// Package of constants for the synthesizer control and clock output block
package scco_pkg;
    // Divider field width for the clock output
    localparam int DIV_WIDTH = 5;
    localparam logic [DIV_WIDTH-1:0] DIV_RESET = 5'h0F;
    // Power-up state of the clock output enable
    localparam logic CLKOUT_EN_RESET = 1'b1;
    // Band select encodings
    localparam logic [1:0] BAND_863_870 = 2'h2;
    localparam logic [1:0] BAND_902_915 = 2'h0;
    localparam logic [1:0] BAND_915_928 = 2'h1;
    localparam logic [1:0] BAND_950_960 = 2'h2;
    // Trim step in millivolts and trim width
    localparam int TRIM_STEP_MV = 60;
    localparam int TRIM_WIDTH = 2;
    localparam int TUNE_WIDTH = 8;
    // Reference divider advisory limits
    localparam int REF_DIV_MIN = 64;
    localparam int REF_DIV_MAX = 169;
    localparam int REF_DIV_ADVISED = 119;
    localparam int REF_DIV_WIDTH = 8;
    localparam int PS_WIDTH = 8;
    // Operating modes
    typedef enum logic [2:0] {
        SCCO_SLEEP = 3'h0,
        SCCO_STBY = 3'h1,
        SCCO_FS = 3'h2,
        SCCO_RX = 3'h3,
        SCCO_TX = 3'h4
    } scco_mode_type;
endpackage : scco_pkg

//--- src/scco_clock_divider.sv
// Clock output divider that produces a toggling output from clock enables
`timescale 1ns/10ps
module scco_clock_divider
    import scco_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic run,
    input wire logic [scco_pkg::DIV_WIDTH-1:0] divider,
    // Output
    output logic clock_out
);
    logic [scco_pkg::DIV_WIDTH-1:0] count;

    // Half period is divider+1 cycles; a stopped divider parks low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 5'h00;
            clock_out <= 1'b0;
        end else if (!run) begin
            count <= 5'h00;
            clock_out <= 1'b0;
        end else if (count >= divider) begin
            count <= 5'h00;
            clock_out <= ~clock_out;
        end else begin
            count <= count + 5'h01;
        end
    end
endmodule : scco_clock_divider

//--- src/scco_synth_control.sv
// Synthesizer control: clock output, band and trim, lock flag and pin
//
// How it works
// - With enable set, drive half-rate reference or divided reference on clock output.
// - Clock output runs in all modes except Sleep, where it stops.
// - Clock output enable comes up set after reset, no write needed.
// - Each trim step raises tuning voltage code by one 60 mV step.
// - Lock flag is readable; host clears it by writing one.
// - With lock pin enable set, lock status drives the lock pin.
`timescale 1ns/10ps
module scco_synth_control
    import scco_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Mode and configuration writes
    input wire scco_pkg::scco_mode_type mode,
    input wire logic clock_out_enable_write,
    input wire logic clock_out_enable_value,
    input wire logic [scco_pkg::DIV_WIDTH-1:0] clock_out_divider,
    input wire logic clock_out_divided,
    input wire logic [1:0] band_select,
    input wire logic [scco_pkg::TRIM_WIDTH-1:0] oscillator_trim,
    input wire logic lock_pin_enable,
    input wire logic lock_flag_clear,
    input wire logic [scco_pkg::REF_DIV_WIDTH-1:0] ref_divider,
    input wire logic [scco_pkg::PS_WIDTH-1:0] p_divider,
    input wire logic [scco_pkg::PS_WIDTH-1:0] s_divider,
    // Lock detector from the analog loop, asynchronous
    input wire logic lock_detect,
    // Status and pins
    output logic clock_out_enable,
    output logic clock_out,
    output logic lock_flag,
    output logic lock_pin,
    output logic [1:0] band_code,
    output logic [scco_pkg::TUNE_WIDTH-1:0] tune_offset_mv,
    output logic divider_setting_ok
);
    import scco_pkg::*;

    logic lock_meta;
    logic lock_sync;
    logic run;
    logic div_clock;

    // Two-stage synchroniser for the analog lock detector
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_meta <= 1'b0;
            lock_sync <= 1'b0;
        end else begin
            lock_meta <= lock_detect;
            lock_sync <= lock_meta;
        end
    end

    // Enable comes up set so a host can boot from this clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clock_out_enable <= CLKOUT_EN_RESET;
        end else if (clock_out_enable_write) begin
            clock_out_enable <= clock_out_enable_value;
        end
    end

    // Sleep gates the output regardless of enable
    assign run = clock_out_enable && (mode != SCCO_SLEEP);

    scco_clock_divider u_divider (
        .clk(clk),
        .reset_n(reset_n),
        .run(run && clock_out_divided),
        .divider(clock_out_divider),
        .clock_out(div_clock)
    );

    // Undivided path toggles this register every cycle, giving half the reference rate;
    // the output always comes straight from this register, so it is glitch-free
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clock_out <= 1'b0;
        end else if (!run) begin
            clock_out <= 1'b0;
        end else if (clock_out_divided) begin
            clock_out <= div_clock;
        end else begin
            clock_out <= ~clock_out;
        end
    end

    // Sticky flag: a new lock in the clear cycle wins over the clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_flag <= 1'b0;
        end else if (lock_sync) begin
            lock_flag <= 1'b1;
        end else if (lock_flag_clear) begin
            lock_flag <= 1'b0;
        end
    end

    // Lock pin mirrors live lock status when enabled
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_pin <= 1'b0;
        end else begin
            lock_pin <= lock_pin_enable && lock_sync;
        end
    end

    // Band code passed to the oscillator, trim scaled to millivolts
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            band_code <= BAND_902_915;
            tune_offset_mv <= 8'h00;
        end else begin
            band_code <= band_select;
            tune_offset_mv <= TUNE_WIDTH'(oscillator_trim * TRIM_STEP_MV);
        end
    end

    // Advisory check only; the device still accepts any value
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            divider_setting_ok <= 1'b0;
        end else begin
            divider_setting_ok <= (32'(ref_divider) >= REF_DIV_MIN) && (32'(ref_divider) <= REF_DIV_MAX)
                && (9'(s_divider) < 9'(p_divider) + 9'h001);
        end
    end

    a_sleep_stops: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == SCCO_SLEEP) [*2] |-> !clock_out)
        else $error("clock output active in sleep");

    a_flag_sticky: assert property (@(posedge clk) disable iff (!reset_n)
        lock_flag && !lock_flag_clear |=> lock_flag)
        else $error("lock flag dropped without clear");

    a_flag_sets: assert property (@(posedge clk) disable iff (!reset_n)
        lock_sync |=> lock_flag)
        else $error("lock flag not set on lock");

    a_flag_clears: assert property (@(posedge clk) disable iff (!reset_n)
        lock_flag_clear && !lock_sync |=> !lock_flag)
        else $error("lock flag not cleared");

    // Three samples in a row let the two-stage synchroniser settle before the pin follows
    sequence s_lock_held3;
        lock_detect ##1 lock_detect ##1 lock_detect;
    endsequence

    sequence s_lock_lost3;
        !lock_detect ##1 !lock_detect ##1 !lock_detect;
    endsequence

    // The pin register samples the enable one cycle before it is seen
    a_lock_pin: assert property (@(posedge clk) disable iff (!reset_n)
        s_lock_held3 |=> lock_pin == $past(lock_pin_enable))
        else $error("lock pin wrong");

    a_lock_pin_low: assert property (@(posedge clk) disable iff (!reset_n)
        s_lock_lost3 |=> !lock_pin)
        else $error("lock pin high without lock");

    a_pin_masked: assert property (@(posedge clk) disable iff (!reset_n)
        !lock_pin_enable |=> !lock_pin)
        else $error("lock pin high while masked");

    // Enable writes land one cycle after the strobe
    a_enable_write: assert property (@(posedge clk) disable iff (!reset_n)
        clock_out_enable_write |=> clock_out_enable == $past(clock_out_enable_value))
        else $error("enable write not taken");

    a_disabled_low: assert property (@(posedge clk) disable iff (!reset_n)
        !clock_out_enable |=> !clock_out)
        else $error("clock output active while disabled");

    // Divided path is one register behind the divider output
    a_divided_follow: assert property (@(posedge clk) disable iff (!reset_n)
        run && clock_out_divided |=> clock_out == $past(div_clock))
        else $error("divided clock not forwarded");

    a_band_copy: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> band_code == $past(band_select))
        else $error("band code not forwarded");

    a_direct_toggle: assert property (@(posedge clk) disable iff (!reset_n)
        (run && !clock_out_divided) [*2] |-> clock_out != $past(clock_out))
        else $error("reference clock not toggling");

    a_enable_reset: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(reset_n) |-> clock_out_enable)
        else $error("enable not set after reset");

    a_trim_step: assert property (@(posedge clk) disable iff (!reset_n)
        $stable(oscillator_trim) |=> tune_offset_mv == TUNE_WIDTH'($past(oscillator_trim) * TRIM_STEP_MV))
        else $error("trim step wrong");
endmodule : scco_synth_control

//--- bench/scco_host_model.sv
// Host model: band and divider settings written toward the block
`timescale 1ns/10ps
module scco_host_model
    import scco_pkg::*;
(
    // Requests from the bench
    input wire logic [1:0] band_index,
    input wire logic [scco_pkg::REF_DIV_WIDTH-1:0] ref_request,
    // Settings toward the block
    output logic [1:0] band_select,
    output logic [scco_pkg::REF_DIV_WIDTH-1:0] ref_divider,
    output logic [scco_pkg::PS_WIDTH-1:0] p_divider,
    output logic [scco_pkg::PS_WIDTH-1:0] s_divider
);
    // Index 0..3 stands for the 863, 902, 915 and 950 MHz bands
    always_comb begin
        case (band_index)
            2'h0: band_select = BAND_863_870;
            2'h1: band_select = BAND_902_915;
            2'h2: band_select = BAND_915_928;
            default: band_select = BAND_950_960;
        endcase
    end
    // Serial clock ceilings the host keeps; the block itself has no serial port here
    localparam int CONFIG_SCK_MAX_MHZ = 6;
    localparam int DATA_SCK_MAX_MHZ = 1;
    // S equal to P sits on the legal edge, so a strict compare slip shows
    assign p_divider = 8'h0A;
    assign s_divider = 8'h0A;
    assign ref_divider = ref_request;
endmodule : scco_host_model

//--- bench/tb_synth_control_clock_out.sv
// Testbench for the synthesizer control and clock output block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fail_count++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module tb_synth_control_clock_out;
    import scco_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    scco_mode_type mode = SCCO_STBY;
    logic en_write = 1'b0, en_value = 1'b0, divided = 1'b0, pin_en = 1'b0, flag_clear = 1'b0, lock_detect = 1'b0;
    logic [DIV_WIDTH-1:0] divider = 5'h01;
    logic [1:0] band_index = 2'h0, band_select, band_code;
    logic [TRIM_WIDTH-1:0] trim = 2'h0;
    logic [REF_DIV_WIDTH-1:0] ref_request = 8'h77, ref_divider;
    logic [PS_WIDTH-1:0] p_divider, s_divider;
    logic clock_out_enable, clock_out, lock_flag, lock_pin, divider_setting_ok;
    logic [TUNE_WIDTH-1:0] tune_offset_mv;
    int fail_count = 0;
    int tests_run = 0;
    // 250 MHz reference clock
    always #2 clk = ~clk;
    scco_host_model u_host (.band_index(band_index), .ref_request(ref_request), .band_select(band_select),
        .ref_divider(ref_divider), .p_divider(p_divider), .s_divider(s_divider));
    scco_synth_control u_dut (.clk(clk), .reset_n(reset_n), .mode(mode), .clock_out_enable_write(en_write),
        .clock_out_enable_value(en_value), .clock_out_divider(divider), .clock_out_divided(divided),
        .band_select(band_select), .oscillator_trim(trim), .lock_pin_enable(pin_en),
        .lock_flag_clear(flag_clear), .ref_divider(ref_divider), .p_divider(p_divider),
        .s_divider(s_divider), .lock_detect(lock_detect), .clock_out_enable(clock_out_enable),
        .clock_out(clock_out), .lock_flag(lock_flag), .lock_pin(lock_pin), .band_code(band_code),
        .tune_offset_mv(tune_offset_mv), .divider_setting_ok(divider_setting_ok));
    task automatic give_verdict();
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // Any whole window of a steady toggle holds an exact count, whatever the phase
    task automatic check_toggles(input int n, input int ex);
        int seen = 0;
        logic last;
        last = clock_out;
        repeat (n) begin
            @(negedge clk);
            seen += (clock_out !== last);
            last = clock_out;
        end
        `CHK("clock_out toggles", ex, seen)
    endtask : check_toggles
    task automatic clock_scenario();
        scco_mode_type modes[4] = '{SCCO_STBY, SCCO_FS, SCCO_RX, SCCO_TX};
        divided = 1'b1;
        for (int i = 0; i < 4; i++) begin
            mode = modes[i];
            cyc(4);
            check_toggles(16, 8);
        end
        divider = 5'h03;
        cyc(8);
        check_toggles(16, 4);
        mode = SCCO_SLEEP;
        cyc(3);
        check_toggles(8, 0);
        `CHK("clock_out sleep", 1'b0, clock_out)
        mode = SCCO_TX;
        en_write = 1'b1;
        cyc(1);
        en_write = 1'b0;
        cyc(2);
        `CHK("clock_out_enable", 1'b0, clock_out_enable)
        check_toggles(8, 0);
        en_value = 1'b1;
        en_write = 1'b1;
        cyc(1);
        en_write = 1'b0;
    endtask : clock_scenario
    task automatic setting_scenario();
        int refs[4] = '{64, 169, 63, 170};
        for (int i = 0; i < 4; i++) begin
            band_index = 2'(i);
            trim = 2'(i);
            ref_request = 8'(refs[i]);
            cyc(2);
            `CHK("band_code", (i == 1) ? 2'h0 : (i == 2) ? 2'h1 : 2'h2, band_code)
            `CHK("tune_offset_mv", 8'(i * 60), tune_offset_mv)
            `CHK("divider_setting_ok", i < 2, divider_setting_ok)
        end
        ref_request = 8'h77;
        cyc(2);
        `CHK("divider_setting_ok", 1'b1, divider_setting_ok)
    endtask : setting_scenario
    task automatic lock_scenario();
        lock_detect = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (lock_flag !== 1'b1) cyc(1);
        end
        `CHK("lock_flag set", 1'b1, lock_flag)
        if (lock_flag !== 1'b1) give_verdict();
        `CHK("lock_pin masked", 1'b0, lock_pin)
        pin_en = 1'b1;
        cyc(2);
        `CHK("lock_pin", 1'b1, lock_pin)
        lock_detect = 1'b0;
        cyc(5);
        `CHK("lock_flag held", 1'b1, lock_flag)
        `CHK("lock_pin lost", 1'b0, lock_pin)
        flag_clear = 1'b1;
        cyc(1);
        flag_clear = 1'b0;
        `CHK("lock_flag cleared", 1'b0, lock_flag)
    endtask : lock_scenario
    // Main sequence: reset for 20 cycles, then each scenario in turn
    initial begin
        cyc(20);
        `CHK("enable in reset", 1'b1, clock_out_enable)
        reset_n = 1'b1;
        cyc(3);
        check_toggles(16, 16);
        clock_scenario();
        setting_scenario();
        lock_scenario();
        give_verdict();
    end
endmodule : tb_synth_control_clock_out
